// *** hdl/oag_top.sv ***
`timescale 1ns/1ps
`include "oag_params.svh"

module oag_top
#(
  parameter int PC_W      = `OAG_PC_W,
  parameter int REG_COUNT = `OAG_REG_COUNT
)
(
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  input  wire logic                  start_i,
  input  wire oag_pkg::oag_mode_type mode_i,
  input  wire oag_pkg::oag_op_type   op_i,
  input  wire oag_pkg::oag_mod_type  modify_i,
  input  wire oag_pkg::oag_ptr_type  ptr_sel_i,
  input  wire logic [7:0]            direct_addr_i,
  input  wire logic [3:0]            reg_idx_i,
  input  wire logic [3:0]            short_imm_i,
  input  wire logic [2:0]            bit_idx_i,
  input  wire logic                  pc_load_i,
  input  wire logic [14:0]           pc_value_i,
  input  wire logic [7:0]            dmem_rdata_i,
  input  wire logic                  dmem_ack_i,
  input  wire logic [7:0]            pmem_rdata_i,
  input  wire logic                  pmem_ack_i,
  output logic                       busy_o,
  output logic                       done_o,
  output logic                       bit_result_o,
  output logic [7:0]                 acc_o,
  output logic [7:0]                 counter_high_byte_o,
  output logic [7:0]                 counter_low_byte_o,
  output logic [7:0]                 dmem_addr_o,
  output logic                       dmem_rd_o,
  output logic                       dmem_wr_o,
  output logic [7:0]                 dmem_wdata_o,
  output logic [14:0]                pmem_addr_o,
  output logic                       pmem_rd_o,
  output logic [7:0]                 ptr_x_o,
  output logic [7:0]                 ptr_b_o,
  output logic [7:0]                 ptr_sp_o
);
  import oag_pkg::*;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (PC_W != `OAG_PC_W || REG_COUNT != `OAG_REG_COUNT)
  begin : g_bad_param
    $error("oag_top serves a 15-bit counter and 16 mapped registers only");
  end

  oag_ptr_if         p ();
  oag_top_state_type r;
  oag_top_state_type n;
  logic              rd_ok;
  logic [7:0]        rd_val;
  logic [7:0]        mask;

  oag_ptr_file oag_ptr_file_i (.clock_i (clock_i), .rst_i (rst_i), .p (p));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // data addresses that hit the pointer store
  function automatic logic is_ptr(input logic [7:0] a);
    return a == `OAG_ADDR_X || a == `OAG_ADDR_SP || a == `OAG_ADDR_B;
  endfunction
  function automatic oag_ptr_type ptr_of(input logic [7:0] a);
    if (a == `OAG_ADDR_X)
      return PTR_X;
    else if (a == `OAG_ADDR_SP)
      return PTR_SP;
    return PTR_B;
  endfunction
  function automatic logic [7:0] ptr_val(input oag_ptr_type s, input logic [7:0] x, b, sp);
    unique case (s)
      PTR_X:   return x;
      PTR_B:   return b;
      default: return sp;
    endcase
  endfunction
  function automatic logic [14:0] instr_len(input oag_mode_type m);
    return (m == AM_DIRECT || m == AM_IMM) ? `OAG_LEN_TWO : `OAG_LEN_ONE;
  endfunction

  // ----------------------------------------
  // access completion and bit mask
  // ----------------------------------------
  assign rd_ok  = r.hit | dmem_ack_i;
  assign rd_val = r.hit ? ptr_val(ptr_of(r.addr), p.x, p.b, p.sp) : dmem_rdata_i;
  assign mask   = 8'h01 << r.bit_idx;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb
  begin
    logic       fin;
    logic [7:0] a;
    fin       = 1'b0;
    a         = 8'h00;
    n         = r;
    n.done    = 1'b0;
    p.wr_en   = 1'b0;
    p.wr_sel  = PTR_B;
    p.wr_data = r.wdata;
    p.mod_en  = 1'b0;
    p.mod_sel = r.sel;
    p.mod_dec = r.modify == MOD_DEC;
    unique case (r.state)
      ST_IDLE:
      begin
        if (start_i)
        begin
          n.mode    = mode_i;
          n.op      = op_i;
          n.modify  = modify_i;
          n.sel     = ptr_sel_i;
          n.bit_idx = bit_idx_i;
          unique case (mode_i)
            AM_DIRECT: a = direct_addr_i;
            AM_REG:    a = {`OAG_REG_PAGE, reg_idx_i};
            default:   a = ptr_val(ptr_sel_i, p.x, p.b, p.sp);
          endcase
          unique case (mode_i)
            AM_IMM:
            begin
              n.pmem_addr = r.pc + `OAG_PC_STEP;
              n.pmem_rd   = 1'b1;
              n.state     = ST_PROG;
            end
            AM_TABLE:
            begin
              n.pmem_addr = {r.pc[14:8], r.acc};
              n.pmem_rd   = 1'b1;
              n.state     = ST_PROG;
            end
            AM_IMM_SHORT:
            begin
              p.wr_en   = 1'b1;
              p.wr_data = {`OAG_NIBBLE_ZERO, short_imm_i};
              fin       = 1'b1;
            end
            default:
            begin
              n.addr  = a;
              n.hit   = is_ptr(a);
              n.rd    = !is_ptr(a);
              n.state = ST_READ;
            end
          endcase
        end
        else if (pc_load_i)
          n.pc = pc_value_i;
      end
      ST_READ:
      begin
        if (rd_ok)
        begin
          n.rd = 1'b0;
          unique case (r.op)
            OP_LOAD:    n.acc = rd_val;
            OP_TESTBIT: n.bit_result = |(rd_val & mask);
            OP_EXCH:
            begin
              n.acc   = rd_val;
              n.wdata = r.acc;
            end
            OP_SETBIT:  n.wdata = rd_val | mask;
            default:    n.wdata = rd_val & ~mask;
          endcase
          if (r.op == OP_LOAD || r.op == OP_TESTBIT)
            fin = 1'b1;
          else
          begin
            n.wr    = !r.hit;
            n.state = ST_WRITE;
          end
        end
      end
      ST_WRITE:
      begin
        if (rd_ok)
        begin
          n.wr      = 1'b0;
          p.wr_en   = r.hit;
          p.wr_sel  = ptr_of(r.addr);
          fin       = 1'b1;
        end
      end
      ST_PROG:
      begin
        if (pmem_ack_i)
        begin
          n.pmem_rd = 1'b0;
          n.acc     = pmem_rdata_i;
          fin       = 1'b1;
        end
      end
    endcase
    // completion: counter moves past the instruction, pointer post-modify
    if (fin)
    begin
      n.done  = 1'b1;
      n.state = ST_IDLE;
      n.pc    = r.pc + instr_len(r.state == ST_IDLE ? mode_i : r.mode);
      p.mod_en = r.state != ST_IDLE && r.mode == AM_IND && r.modify != MOD_NONE;
    end
    n.busy = n.state != ST_IDLE; // kept in a flop so busy_o is registered
  end

  // state register
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      r       <= '0;
      r.state <= ST_IDLE;
      r.acc   <= `OAG_ACC_RESET;
      r.pc    <= `OAG_PC_RESET;
    end
    else
      r <= n;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign busy_o              = r.busy;
  assign done_o              = r.done;
  assign bit_result_o        = r.bit_result;
  assign acc_o               = r.acc;
  assign counter_high_byte_o = {1'b0, r.pc[14:8]};
  assign counter_low_byte_o  = r.pc[7:0];
  assign dmem_addr_o         = r.addr;
  assign dmem_rd_o           = r.rd;
  assign dmem_wr_o           = r.wr;
  assign dmem_wdata_o        = r.wdata;
  assign pmem_addr_o         = r.pmem_addr;
  assign pmem_rd_o           = r.pmem_rd;
  assign ptr_x_o             = p.x;
  assign ptr_b_o             = p.b;
  assign ptr_sp_o            = p.sp;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_start(oag_mode_type m);
    r.state == ST_IDLE && start_i && mode_i == m;
  endsequence
  sequence s_set_read;
    r.state == ST_READ && r.op == OP_SETBIT && rd_ok;
  endsequence
  sequence s_table_end;
    r.state == ST_PROG && r.mode == AM_TABLE && pmem_ack_i;
  endsequence
  direct_addr_a: assert property (s_start(AM_DIRECT) |=> dmem_addr_o == $past(direct_addr_i))
    else $error("direct address not taken from instruction");
  indirect_addr_a: assert property (s_start(AM_IND) ##0 ptr_sel_i == PTR_X |=> dmem_addr_o == $past(p.x))
    else $error("indirect address not taken from pointer");
  post_inc_a: assert property (done_o && r.mode == AM_IND && r.modify == MOD_INC && !r.hit && r.sel == PTR_B
    |-> p.b == $past(p.b) + `OAG_PTR_STEP) else $error("pointer not incremented after access");
  imm_fetch_a: assert property (s_start(AM_IMM) |=> pmem_rd_o && pmem_addr_o == $past(r.pc) + 15'h0001)
    else $error("immediate not fetched after opcode");
  short_imm_a: assert property (s_start(AM_IMM_SHORT) |=> p.b == {`OAG_NIBBLE_ZERO, $past(short_imm_i)} && done_o)
    else $error("short immediate load wrong");
  table_addr_a: assert property (s_start(AM_TABLE) |=> pmem_addr_o == {$past(r.pc[14:8]), $past(r.acc)})
    else $error("table address not formed from accumulator");
  table_result_a: assert property (s_table_end |=> acc_o == $past(pmem_rdata_i)
    && counter_low_byte_o == $past(r.pc[7:0]) + 8'h01) else $error("table read result or counter wrong");
  set_bit_a: assert property (s_set_read |=> r.state == ST_WRITE ##0 dmem_wdata_o == ($past(rd_val) | $past(mask)))
    else $error("set bit value wrong");
  ptr_internal_a: assert property (r.state == ST_READ && r.hit |-> !dmem_rd_o)
    else $error("mapped pointer read went to memory");
  reg_map_a: assert property (s_start(AM_REG) |=> dmem_addr_o == {`OAG_REG_PAGE, $past(reg_idx_i)})
    else $error("register index mapped wrong");
  pc_top_a: assert property (r.state == ST_IDLE && !start_i && pc_load_i
    |=> counter_high_byte_o == {1'b0, $past(pc_value_i[14:8])} && counter_low_byte_o == $past(pc_value_i[7:0]))
    else $error("counter bytes not split from loaded value");
endmodule

// *** shared/oag_params.svh ***
`ifndef OAG_PARAMS_SVH
`define OAG_PARAMS_SVH

// ----------------------------------------
// data memory map of the pointer block
// ----------------------------------------
`define OAG_REG_PAGE    4'hF
`define OAG_ADDR_X      8'hFC
`define OAG_ADDR_SP     8'hFD
`define OAG_ADDR_B      8'hFE
`define OAG_NIBBLE_ZERO 4'h0

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define OAG_PC_W        15
`define OAG_REG_COUNT   16
`define OAG_PTR_RESET   8'h00
`define OAG_ACC_RESET   8'h00
`define OAG_PC_RESET    15'h0000
`define OAG_PTR_STEP    8'h01
`define OAG_PC_STEP     15'h0001
`define OAG_LEN_ONE     15'h0001
`define OAG_LEN_TWO     15'h0002

`endif

// *** shared/oag_pkg.sv ***
`include "oag_params.svh"

package oag_pkg;

  // ----------------------------------------
  // modes, operations and states
  // ----------------------------------------
  typedef enum logic [2:0] {AM_DIRECT, AM_REG, AM_IND, AM_IMM, AM_IMM_SHORT, AM_TABLE} oag_mode_type;
  typedef enum logic [2:0] {OP_LOAD, OP_EXCH, OP_SETBIT, OP_CLRBIT, OP_TESTBIT} oag_op_type;
  typedef enum logic [1:0] {MOD_NONE, MOD_INC, MOD_DEC} oag_mod_type;
  typedef enum logic [1:0] {PTR_X, PTR_B, PTR_SP} oag_ptr_type;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_PROG} oag_state_type;

  // ----------------------------------------
  // state records
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] x;
    logic [7:0] b;
    logic [7:0] sp;
  } oag_ptr_state_type;

  typedef struct packed {
    oag_state_type            state;
    logic                     busy;
    oag_mode_type             mode;
    oag_op_type               op;
    oag_mod_type              modify;
    oag_ptr_type              sel;
    logic [2:0]               bit_idx;
    logic                     hit;
    logic [7:0]               acc;
    logic [`OAG_PC_W-1:0]     pc;
    logic [7:0]               addr;
    logic                     rd;
    logic                     wr;
    logic [7:0]               wdata;
    logic [`OAG_PC_W-1:0]     pmem_addr;
    logic                     pmem_rd;
    logic                     done;
    logic                     bit_result;
  } oag_top_state_type;

endpackage

// *** shared/oag_ptr_if.sv ***
`timescale 1ns/1ps

// pointer file access between the sequencer and the pointer store
interface oag_ptr_if;
  import oag_pkg::*;
  logic        wr_en;
  oag_ptr_type wr_sel;
  logic [7:0]  wr_data;
  logic        mod_en;
  oag_ptr_type mod_sel;
  logic        mod_dec;
  logic [7:0]  x;
  logic [7:0]  b;
  logic [7:0]  sp;

  modport store (input wr_en, wr_sel, wr_data, mod_en, mod_sel, mod_dec, output x, b, sp);
  modport user  (output wr_en, wr_sel, wr_data, mod_en, mod_sel, mod_dec, input x, b, sp);
endinterface

// *** hdl/oag_ptr_file.sv ***
`timescale 1ns/1ps

module oag_ptr_file
(
  input  wire logic   clock_i,
  input  wire logic   rst_i,
  oag_ptr_if.store    p
);
  import oag_pkg::*;

  oag_ptr_state_type r;
  oag_ptr_state_type n;

  // ----------------------------------------
  // pointer store: write first, then post-modify
  // ----------------------------------------
  always_comb
  begin
    logic [7:0] v;
    v = 8'h00;
    n = r;
    if (p.wr_en)
    begin
      unique case (p.wr_sel)
        PTR_X:  n.x  = p.wr_data;
        PTR_B:  n.b  = p.wr_data;
        PTR_SP: n.sp = p.wr_data;
      endcase
    end
    if (p.mod_en)
    begin
      unique case (p.mod_sel)
        PTR_X:  v = n.x;
        PTR_B:  v = n.b;
        PTR_SP: v = n.sp;
      endcase
      // eight-bit step wraps modulo 256
      v = p.mod_dec ? v - `OAG_PTR_STEP : v + `OAG_PTR_STEP;
      unique case (p.mod_sel)
        PTR_X:  n.x  = v;
        PTR_B:  n.b  = v;
        PTR_SP: n.sp = v;
      endcase
    end
  end

  // state register
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      r <= '{x: `OAG_PTR_RESET, b: `OAG_PTR_RESET, sp: `OAG_PTR_RESET};
    else
      r <= n;
  end

  assign p.x  = r.x;
  assign p.b  = r.b;
  assign p.sp = r.sp;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  wrap_down_a: assert property (p.mod_en && p.mod_dec && !p.wr_en && p.mod_sel == PTR_X && p.x == 8'h00
    |=> p.x == 8'hFF) else $error("pointer decrement did not wrap to ff");
  others_kept_a: assert property (p.mod_en && !p.wr_en && p.mod_sel == PTR_B
    |=> p.x == $past(p.x) && p.sp == $past(p.sp)) else $error("pointer step touched another pointer");
endmodule

// *** dv/operand_address_generation_bench.sv ***
`timescale 1ns/1ps

module operand_address_generation_bench;
  import oag_pkg::*;

  localparam int TIMEOUT_CYCLES = 3000;

  logic         clock_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         start_i = 1'b0;
  oag_mode_type mode_i = AM_DIRECT;
  oag_op_type   op_i = OP_LOAD;
  oag_mod_type  modify_i = MOD_NONE;
  oag_ptr_type  ptr_sel_i = PTR_X;
  logic [7:0]   direct_addr_i = 8'h00;
  logic [3:0]   nib = 4'h0;
  logic [2:0]   bit_idx_i = 3'h0;
  logic         pc_load_i = 1'b0;
  logic [14:0]  pc_value_i = 15'h0000;
  logic [7:0]   dmem_rdata_i = 8'h00;
  logic         dmem_ack_i = 1'b0;
  logic [7:0]   pmem_rdata_i = 8'h00;
  logic         pmem_ack_i = 1'b0;
  logic         busy_o, done_o, bit_result_o, dmem_rd_o, dmem_wr_o, pmem_rd_o;
  logic [7:0]   acc_o, hi_o, lo_o, dmem_addr_o, dmem_wdata_o, ptr_x_o, ptr_b_o, ptr_sp_o;
  logic [14:0]  pmem_addr_o;
  logic [7:0]   dmem [0:255];
  logic [7:0]   pmem [0:32767];
  logic [14:0]  exp_pc;
  int           mismatches = 0;
  int           cmp_count = 0;
  int           cycles = 0;

  oag_top oag_top_i (.clock_i(clock_i), .rst_i(rst_i), .start_i(start_i), .mode_i(mode_i), .op_i(op_i),
    .modify_i(modify_i), .ptr_sel_i(ptr_sel_i), .direct_addr_i(direct_addr_i), .reg_idx_i(nib),
    .short_imm_i(nib), .bit_idx_i(bit_idx_i), .pc_load_i(pc_load_i), .pc_value_i(pc_value_i),
    .dmem_rdata_i(dmem_rdata_i), .dmem_ack_i(dmem_ack_i), .pmem_rdata_i(pmem_rdata_i),
    .pmem_ack_i(pmem_ack_i), .busy_o(busy_o), .done_o(done_o), .bit_result_o(bit_result_o),
    .acc_o(acc_o), .counter_high_byte_o(hi_o), .counter_low_byte_o(lo_o), .dmem_addr_o(dmem_addr_o),
    .dmem_rd_o(dmem_rd_o), .dmem_wr_o(dmem_wr_o), .dmem_wdata_o(dmem_wdata_o), .pmem_addr_o(pmem_addr_o),
    .pmem_rd_o(pmem_rd_o), .ptr_x_o(ptr_x_o), .ptr_b_o(ptr_b_o), .ptr_sp_o(ptr_sp_o));

  // ----------------------------------------
  // clock, memories with one wait cycle, timeout
  // ----------------------------------------
  initial
  begin
    forever #20 clock_i = ~clock_i;
  end

  // ack one cycle after each strobe is seen, then drop
  always @(posedge clock_i)
  begin
    dmem_ack_i <= (dmem_rd_o | dmem_wr_o) & ~dmem_ack_i;
    dmem_rdata_i <= dmem[dmem_addr_o];
    if (dmem_wr_o && dmem_ack_i)
      dmem[dmem_addr_o] <= dmem_wdata_o;
    pmem_ack_i <= pmem_rd_o & ~pmem_ack_i;
    pmem_rdata_i <= pmem[pmem_addr_o];
    cycles <= cycles + 1;
    if (cycles == TIMEOUT_CYCLES)
    begin
      mismatches++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] expected, input string what);
    cmp_count++;
    if (seen !== expected)
    begin
      mismatches++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, expected);
    end
  endtask

  // one instruction; waits for done under a bound, then checks the counter
  task automatic issue(input oag_mode_type m, input oag_op_type o, input oag_mod_type md,
                       input oag_ptr_type s, input logic [7:0] a, input logic [3:0] n,
                       input logic [2:0] bi, input logic [14:0] len);
    int n_wait;
    @(posedge clock_i);
    start_i <= 1'b1;
    mode_i <= m;
    op_i <= o;
    modify_i <= md;
    ptr_sel_i <= s;
    direct_addr_i <= a;
    nib <= n;
    bit_idx_i <= bi;
    @(posedge clock_i);
    start_i <= 1'b0;
    #1;
    n_wait = 0;
    while (done_o !== 1'b1 && n_wait < 40)
    begin
      @(posedge clock_i);
      #1;
      n_wait++;
    end
    check(done_o, 1'b1, "done");
    check({busy_o, dmem_rd_o, dmem_wr_o, pmem_rd_o}, 4'h0, "idle strobes");
    exp_pc = exp_pc + len;
    check({hi_o, lo_o}, {1'b0, exp_pc}, "counter");
  endtask

  task automatic set_pc(input logic [14:0] v);
    @(posedge clock_i);
    pc_load_i <= 1'b1;
    pc_value_i <= v;
    @(posedge clock_i);
    pc_load_i <= 1'b0;
    #1;
    exp_pc = v;
    check({hi_o, lo_o}, {1'b0, v}, "pc load");
  endtask

  task automatic imm_load(input logic [7:0] v);
    logic [14:0] at;
    at = exp_pc + 15'h0001;
    pmem[at] = v;
    issue(AM_IMM, OP_LOAD, MOD_NONE, PTR_X, 8'h00, 4'h0, 3'h0, 15'h0002);
    check(acc_o, v, "imm acc");
    check(pmem_addr_o, at, "imm addr");
  endtask

  task automatic direct(input oag_op_type o, input logic [7:0] a, input logic [2:0] bi);
    issue(AM_DIRECT, o, MOD_NONE, PTR_X, a, 4'h0, bi, 15'h0002);
  endtask

  task automatic short_b(input logic [3:0] n);
    issue(AM_IMM_SHORT, OP_LOAD, MOD_NONE, PTR_X, 8'h00, n, 3'h0, 15'h0001);
    check(ptr_b_o, {4'h0, n}, "short b");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check({acc_o, ptr_x_o}, 16'h0000, "reset acc x");
    check({ptr_b_o, ptr_sp_o}, 16'h0000, "reset b sp");
    check({busy_o, done_o}, 16'h0000, "reset busy");
  endtask

  task automatic t_pointers();
    set_pc(15'h0100);
    imm_load(8'h12);
    direct(OP_EXCH, 8'hFE, 3'h0);
    check({ptr_b_o, acc_o}, 16'h1200, "b mapped");
    short_b(4'h7);
    short_b(4'hF);
    imm_load(8'h9A);
    direct(OP_EXCH, 8'hFD, 3'h0);
    check({ptr_sp_o, acc_o}, 16'h9A00, "sp mapped");
  endtask

  task automatic t_direct();
    dmem[8'h05] = 8'hA6;
    direct(OP_LOAD, 8'h05, 3'h0);
    check({dmem_addr_o, acc_o}, 16'h05A6, "direct load");
  endtask

  task automatic t_indirect();
    short_b(4'h5);
    dmem[8'h05] = 8'h62;
    imm_load(8'h03);
    issue(AM_IND, OP_EXCH, MOD_INC, PTR_B, 8'h00, 4'h0, 3'h0, 15'h0001);
    check({acc_o, dmem[8'h05]}, 16'h6203, "ind exch");
    check(ptr_b_o, 8'h06, "post inc");
  endtask

  task automatic t_wrap();
    imm_load(8'hFF);
    direct(OP_EXCH, 8'hFE, 3'h0);
    dmem[8'hFF] = 8'h3C;
    issue(AM_IND, OP_LOAD, MOD_INC, PTR_B, 8'h00, 4'h0, 3'h0, 15'h0001);
    check({acc_o, ptr_b_o}, 16'h3C00, "inc wrap");
    check(ptr_x_o, 8'h00, "x kept");
    dmem[8'h00] = 8'h11;
    issue(AM_IND, OP_LOAD, MOD_DEC, PTR_X, 8'h00, 4'h0, 3'h0, 15'h0001);
    check({acc_o, ptr_x_o}, 16'h11FF, "dec wrap");
    check(ptr_b_o, 8'h00, "b kept");
  endtask

  task automatic t_register();
    dmem[8'hF3] = 8'h5C;
    issue(AM_REG, OP_LOAD, MOD_NONE, PTR_X, 8'h00, 4'h3, 3'h0, 15'h0001);
    check({dmem_addr_o, acc_o}, 16'hF35C, "reg load");
  endtask

  task automatic t_bits();
    dmem[8'h40] = 8'h15;
    direct(OP_SETBIT, 8'h40, 3'h7);
    check(dmem[8'h40], 8'h95, "set bit");
    direct(OP_TESTBIT, 8'h40, 3'h7);
    check(bit_result_o, 1'b1, "test one");
    direct(OP_CLRBIT, 8'h40, 3'h0);
    check(dmem[8'h40], 8'h94, "clr bit");
    direct(OP_TESTBIT, 8'h40, 3'h0);
    check(bit_result_o, 1'b0, "test zero");
  endtask

  task automatic t_table();
    imm_load(8'h1F);
    set_pc(15'h0435);
    pmem[15'h041F] = 8'h25;
    issue(AM_TABLE, OP_LOAD, MOD_NONE, PTR_X, 8'h00, 4'h0, 3'h0, 15'h0001);
    check(pmem_addr_o, 15'h041F, "table addr");
    check(acc_o, 8'h25, "table acc");
    set_pc(15'h7F35);
    check(hi_o, 8'h7F, "high byte");
  endtask

  // ----------------------------------------
  // closing report
  // ----------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    exp_pc = 15'h0000;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    #1;
    t_reset();
    t_pointers();
    t_direct();
    t_indirect();
    t_wrap();
    t_register();
    t_bits();
    t_table();
    end_of_test();
  end
endmodule
